// file: ias_defs.vh
`ifndef IAS_DEFS_VH
`define IAS_DEFS_VH

// timebase: oscillator divided by 4, terminal count of the divider
`define IAS_DIV_LAST 2'h3

// phase codes driven to the converter
`define IAS_CODE_CLEAR 2'h0
`define IAS_CODE_NULL 2'h1
`define IAS_CODE_INT 2'h2
`define IAS_CODE_DEINT 2'h3

// phase length byte: upper half of the timebase counter
`define IAS_LEN_RST 8'h00
`define IAS_LEN_SHORT_HI 8'h00
`define IAS_LEN_SHORT_LO 8'h80
`define IAS_CNT_LOW 8'h00
`define IAS_CNT_LAST 16'hFFFF
`define IAS_LOAD_BITS 4'h8

// result frame
`define IAS_FRAME_W 18
`define IAS_MAG_MAX 17'h1FFFF

// register byte offsets
`define IAS_ADR_CTRL 4'h0
`define IAS_ADR_LEN 4'h4
`define IAS_ADR_STAT 4'h8
`define IAS_ADR_RES 4'hC

// field positions
`define IAS_CTRL_HOLD 0
`define IAS_STAT_VALID_N 2
`define IAS_STAT_HOLD 3
`define IAS_STAT_READ 4
`define IAS_STAT_LOAD 5

// reset values
`define IAS_CTRL_RST 1'b0
`define IAS_RES_RST 18'h00000
// idle pin levels {zc, ce_n, ld_n, rd_n, din, sclk}: selects high, rest low
`define IAS_PIN_IDLE 6'h0C
`define IAS_OE_N_RST 1'b1

`endif

// file: ias_sync.v
`timescale 1ns/10ps
`default_nettype none

module ias_sync #(
  parameter W = 6
) (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire [W-1:0] d_i,
  input wire [W-1:0] rst_val_i,
  output wire [W-1:0] q_o
);

  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;

  // two flops per pin; the first is read only by the second
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : bit_g
      always @(posedge clk_i) begin
        if (rst_i) begin
          meta_reg[g] <= rst_val_i[g];
          sync_reg[g] <= rst_val_i[g];
        end else if (ce_i) begin
          meta_reg[g] <= d_i[g];
          sync_reg[g] <= meta_reg[g];
        end
      end
    end
  endgenerate

  // both flops reset to the idle level, so release brings no false edge
  assign q_o = sync_reg;

endmodule

`default_nettype wire

// file: ias_timebase.v
`timescale 1ns/10ps
`default_nettype none
`include "ias_defs.vh"

module ias_timebase (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  output wire tick_o
);

  reg [1:0] div_reg;

  // free running divide by four
  always @(posedge clk_i) begin
    if (rst_i) begin
      div_reg <= 2'h0;
    end else if (ce_i) begin
      div_reg <= div_reg + 2'h1;
    end
  end

  // one clock wide strobe per divided period
  assign tick_o = ce_i & (div_reg == `IAS_DIV_LAST);

endmodule

`default_nettype wire

// file: ias_adapter.v
// Added by the designer: register access over Wishbone and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "ias_defs.vh"

// Summary of operation
// - read select fall loads latest result
// - frame: overrange, sign, 16-bit magnitude MSB-first
// - sign high positive, low negative
// - overrange visible at read select fall
// - serial out driven only during read select
// - read select high abandons read, floats output
// - sample in on rise, shift out on fall
// - phase length byte arrives MSB first
// - load select low shifts into holding register
// - load select high moves byte to counter
// - short load pulse: serial in picks length
// - valid output low during offset-null phase
// - convert enable low runs cycles back-to-back
// - convert enable high forces offset-null hold
// - phase codes 01,10,11,00 per phase
// - zero-cross falling edge ends de-integrate
// - timebase is oscillator divided by four
// - clear phase waits for zero-cross rise; code waits on the zero-cross high level

module ias_adapter (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire serial_clock_i,
  input wire serial_in_i,
  input wire read_sel_n_i,
  input wire load_sel_n_i,
  input wire convert_enable_n_i,
  input wire zero_cross_input_i,
  output wire serial_out_o,
  output wire serial_out_oe_n_o,
  output reg conversion_valid_n_o,
  output reg [1:0] phase_code_o
);

  // sequencer states, binary coded
  localparam ST_CLEAR = 2'd0;
  localparam ST_NULL = 2'd1;
  localparam ST_INT = 2'd2;
  localparam ST_DEINT = 2'd3;

  // state to converter phase code
  function [1:0] phase_code;
    input [1:0] st;
    begin
      case (st)
        ST_CLEAR: phase_code = `IAS_CODE_CLEAR;
        ST_NULL: phase_code = `IAS_CODE_NULL;
        ST_INT: phase_code = `IAS_CODE_INT;
        ST_DEINT: phase_code = `IAS_CODE_DEINT;
        default: phase_code = `IAS_CODE_CLEAR;
      endcase
    end
  endfunction

  // register offset match, shared by the write decodes
  function offset_hit;
    input [3:0] adr;
    input [3:0] off;
    begin
      offset_hit = (adr == off);
    end
  endfunction

  // timebase strobe and synchronised pin copies
  wire tick;
  wire [5:0] pin_s;
  wire sclk_s;
  wire din_s;
  wire rd_n_s;
  wire ld_n_s;
  wire ce_n_s;
  wire zc_s;

  // sequencer, result and serial port state
  reg [5:0] pin_d_reg;
  reg [1:0] st_reg;
  reg [15:0] cnt_reg;
  reg [16:0] mag_reg;
  reg sign_reg;
  reg zc_fell_reg;
  reg [17:0] res_reg;
  reg [7:0] len_reg;
  reg [7:0] hold_reg;
  reg [3:0] ld_cnt_reg;
  reg [17:0] sh_reg;
  reg ctrl_hold_reg;
  reg oe_n_reg;

  // divided timebase strobe
  ias_timebase u_tb (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .tick_o(tick)
  );

  // every pin passes two flops before use
  // flops start at idle levels so no read or load is seen at release
  ias_sync #(
    .W(6)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i({zero_cross_input_i, convert_enable_n_i, load_sel_n_i,
          read_sel_n_i, serial_in_i, serial_clock_i}),
    .rst_val_i(`IAS_PIN_IDLE),
    .q_o(pin_s)
  );

  assign sclk_s = pin_s[0];
  assign din_s = pin_s[1];
  assign rd_n_s = pin_s[2];
  assign ld_n_s = pin_s[3];
  assign ce_n_s = pin_s[4];
  assign zc_s = pin_s[5];

  // edge history of synchronised pins
  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_d_reg <= `IAS_PIN_IDLE;
    end else if (ce_i) begin
      pin_d_reg <= pin_s;
    end
  end

  wire sclk_rise = sclk_s & ~pin_d_reg[0];
  wire sclk_fall = ~sclk_s & pin_d_reg[0];
  wire rd_fall = ~rd_n_s & pin_d_reg[2];
  wire ld_fall = ~ld_n_s & pin_d_reg[3];
  wire ld_rise = ld_n_s & ~pin_d_reg[3];
  wire zc_fall = ~zc_s & pin_d_reg[5];

  // pin or software hold both force offset-null
  wire hold = ce_n_s | ctrl_hold_reg;

  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr = wb_req & wb_we_i & wb_sel_i[0];

  // conversion sequencer, stepped on the divided timebase
  always @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= ST_CLEAR;
      cnt_reg <= {`IAS_LEN_RST, `IAS_CNT_LOW};
      mag_reg <= 17'h00000;
      sign_reg <= 1'b0;
      res_reg <= `IAS_RES_RST;
    end else if (ce_i) begin
      if (hold) begin
        // suspended: sit in offset-null, restart its count
        st_reg <= ST_NULL;
        cnt_reg <= {len_reg, `IAS_CNT_LOW};
      end else if (tick) begin
        case (st_reg)
          ST_CLEAR: begin
            // integrator settled once comparator is back high
            if (zc_s) begin
              st_reg <= ST_NULL;
              cnt_reg <= {len_reg, `IAS_CNT_LOW};
            end
          end
          ST_NULL: begin
            if (cnt_reg == `IAS_CNT_LAST) begin
              st_reg <= ST_INT;
              cnt_reg <= {len_reg, `IAS_CNT_LOW};
            end else begin
              cnt_reg <= cnt_reg + 16'h0001;
            end
          end
          ST_INT: begin
            if (cnt_reg == `IAS_CNT_LAST) begin
              st_reg <= ST_DEINT;
              mag_reg <= 17'h00000;
              // comparator high after integrate means input positive
              sign_reg <= zc_s;
            end else begin
              cnt_reg <= cnt_reg + 16'h0001;
            end
          end
          ST_DEINT: begin
            if (zc_fell_reg) begin
              st_reg <= ST_CLEAR;
              res_reg <= {mag_reg[16], sign_reg, mag_reg[15:0]};
            end else if (mag_reg != `IAS_MAG_MAX) begin
              // carry out of 16 bits becomes overrange, then saturates
              mag_reg <= mag_reg + 17'h00001;
            end
          end
          default: begin
            st_reg <= ST_CLEAR;
          end
        endcase
      end
    end
  end

  // comparator fall is caught at full rate, acted on at the next tick
  always @(posedge clk_i) begin
    if (rst_i) begin
      zc_fell_reg <= 1'b0;
    end else if (ce_i) begin
      if (st_reg != ST_DEINT || hold) begin
        zc_fell_reg <= 1'b0;
      end else if (zc_fall) begin
        zc_fell_reg <= 1'b1;
      end
    end
  end

  // converter control outputs registered from the state
  always @(posedge clk_i) begin
    if (rst_i) begin
      phase_code_o <= `IAS_CODE_CLEAR;
      conversion_valid_n_o <= 1'b1;
    end else if (ce_i) begin
      phase_code_o <= phase_code(st_reg);
      conversion_valid_n_o <= (st_reg != ST_NULL);
    end
  end

  // phase length load port and bus write of the same byte
  always @(posedge clk_i) begin
    if (rst_i) begin
      len_reg <= `IAS_LEN_RST;
      hold_reg <= 8'h00;
      ld_cnt_reg <= 4'h0;
    end else if (ce_i) begin
      if (ld_fall) begin
        ld_cnt_reg <= 4'h0;
      end else if (~ld_n_s && sclk_rise) begin
        // MSB arrives first, so shift toward the top
        hold_reg <= {hold_reg[6:0], din_s};
        if (ld_cnt_reg != `IAS_LOAD_BITS) begin
          ld_cnt_reg <= ld_cnt_reg + 4'h1;
        end
      end
      if (ld_rise) begin
        if (ld_cnt_reg == 4'h0) begin
          // no bits clocked: serial in level picks the length
          len_reg <= din_s ? `IAS_LEN_SHORT_HI : `IAS_LEN_SHORT_LO;
        end else begin
          len_reg <= hold_reg;
        end
      end else if (wb_wr && offset_hit(wb_adr_i, `IAS_ADR_LEN)) begin
        len_reg <= wb_dat_i[7:0];
      end
    end
  end

  // result shifter toward the host
  always @(posedge clk_i) begin
    if (rst_i) begin
      sh_reg <= `IAS_RES_RST;
    end else if (ce_i) begin
      if (rd_fall) begin
        // overrange lands on the output bit at once
        sh_reg <= res_reg;
      end else if (~rd_n_s && sclk_fall) begin
        sh_reg <= {sh_reg[16:0], 1'b0};
      end
    end
  end

  // enable drops at the same edge as the load, so the first
  // driven bit is already overrange, never a stale shifter bit
  always @(posedge clk_i) begin
    if (rst_i) begin
      oe_n_reg <= `IAS_OE_N_RST;
    end else if (ce_i) begin
      if (rd_n_s) begin
        // a raise abandons the read and floats the pin at once
        oe_n_reg <= 1'b1;
      end else if (rd_fall) begin
        oe_n_reg <= 1'b0;
      end
    end
  end

  // serial data straight from the shifter flop
  assign serial_out_o = sh_reg[17];
  assign serial_out_oe_n_o = oe_n_reg;

  // bus control register
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_hold_reg <= `IAS_CTRL_RST;
    end else if (ce_i) begin
      if (wb_wr && offset_hit(wb_adr_i, `IAS_ADR_CTRL)) begin
        ctrl_hold_reg <= wb_dat_i[`IAS_CTRL_HOLD];
      end
    end
  end

  // classic wishbone slave: ack one cycle after the request
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else if (ce_i) begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h00000000;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          `IAS_ADR_CTRL: begin
            wb_dat_o[`IAS_CTRL_HOLD] <= ctrl_hold_reg;
          end
          `IAS_ADR_LEN: begin
            wb_dat_o[7:0] <= len_reg;
          end
          `IAS_ADR_STAT: begin
            wb_dat_o[1:0] <= phase_code_o;
            wb_dat_o[`IAS_STAT_VALID_N] <= conversion_valid_n_o;
            wb_dat_o[`IAS_STAT_HOLD] <= hold;
            wb_dat_o[`IAS_STAT_READ] <= ~rd_n_s;
            wb_dat_o[`IAS_STAT_LOAD] <= ~ld_n_s;
          end
          `IAS_ADR_RES: begin
            wb_dat_o[17:0] <= res_reg;
          end
          default: begin
            // unmapped offsets read zero and still ack
            wb_dat_o <= 32'h00000000;
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// file: ias_adapter_chk.sv
`timescale 1ns/10ps
`default_nettype none
module ias_adapter_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic read_sel_n_i,
  input wire logic convert_enable_n_i,
  input wire logic zero_cross_input_i,
  input wire logic serial_out_oe_n_o,
  input wire logic conversion_valid_n_o,
  input wire logic [1:0] phase_code_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // bus: one answer one cycle later, then dropped
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("bus ack wrong");
  property p_valid; conversion_valid_n_o == (phase_code_o != 2'h1); endproperty
  a_valid: assert property (p_valid) else $error("valid flag wrong");
  // phases step in order; a hold may cut to offset-null from anywhere
  property p_order; phase_code_o != $past(phase_code_o) |->
    phase_code_o == 2'h1 || phase_code_o == $past(phase_code_o) + 2'h1; endproperty
  a_order: assert property (p_order) else $error("phase order wrong");
  property p_hold; convert_enable_n_i [*8] |-> phase_code_o == 2'h1; endproperty
  a_hold: assert property (p_hold) else $error("hold not obeyed");
  property p_rd_off; read_sel_n_i [*4] |-> serial_out_oe_n_o; endproperty
  a_rd_off: assert property (p_rd_off) else $error("output not floated");
  property p_rd_on; !read_sel_n_i [*4] |-> !serial_out_oe_n_o; endproperty
  a_rd_on: assert property (p_rd_on) else $error("output not driven");
  // sync latency is covered by the eight-cycle history
  property p_clear; (!zero_cross_input_i && !convert_enable_n_i) [*8] ##0 phase_code_o == 2'h0
    |=> phase_code_o == 2'h0; endproperty
  a_clear: assert property (p_clear) else $error("clear left early");
  property p_deint; (zero_cross_input_i && !convert_enable_n_i) [*8] ##0 phase_code_o == 2'h3
    |=> phase_code_o == 2'h3; endproperty
  a_deint: assert property (p_deint) else $error("deintegrate left early");
endmodule
bind ias_adapter ias_adapter_chk u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .read_sel_n_i,
  .convert_enable_n_i, .zero_cross_input_i, .serial_out_oe_n_o, .conversion_valid_n_o, .phase_code_o);
`default_nettype wire

// file: ias_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module ias_host_model (
  input wire logic clk_i,
  input wire logic serial_out_i,
  output logic serial_clock_o,
  output logic serial_in_o,
  output logic read_sel_n_o,
  output logic load_sel_n_o
);
  // 84 clocks a period keeps the serial clock just under 3MHz
  localparam int HALF = 42;
  initial begin
    serial_clock_o = 1'b0;
    serial_in_o = 1'b0;
    read_sel_n_o = 1'b1;
    load_sel_n_o = 1'b1;
  end
  // clock stands low outside frames
  task automatic pulse();
    serial_clock_o <= 1'b1;
    repeat (HALF) @(posedge clk_i);
    serial_clock_o <= 1'b0;
    repeat (HALF) @(posedge clk_i);
  endtask
  task automatic read_frame(input int n, output logic [17:0] bits);
    bits = 18'h00000;
    @(posedge clk_i);
    read_sel_n_o <= 1'b0;
    repeat (6) @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      bits = {bits[16:0], serial_out_i};
      pulse();
    end
    read_sel_n_o <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask
  // nbits of zero gives a bare pulse, serial_in picking the length
  task automatic load(input logic [7:0] v, input int nbits);
    logic [7:0] s;
    s = v;
    @(posedge clk_i);
    serial_in_o <= (nbits == 0) ? v[0] : v[7];
    load_sel_n_o <= 1'b0;
    for (int i = 0; i < nbits; i++) begin
      repeat (HALF) @(posedge clk_i);
      pulse();
      s = s << 1;
      serial_in_o <= s[7];
    end
    repeat (HALF) @(posedge clk_i);
    load_sel_n_o <= 1'b1;
    repeat (6) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// file: ias_adapter_bench.sv
`timescale 1ns/10ps
`default_nettype none
module ias_adapter_bench;
  logic clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic serial_clock_i, serial_in_i, read_sel_n_i, load_sel_n_i, serial_out_o, serial_out_oe_n_o;
  logic convert_enable_n_i, zero_cross_input_i, conversion_valid_n_o;
  logic [3:0] wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [1:0] phase_code_o;
  logic [17:0] f;
  logic [16:0] m;
  int n_errors = 0;
  int comparisons = 0;
  ias_adapter u_ias_adapter (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .serial_clock_i, .serial_in_i, .read_sel_n_i, .load_sel_n_i,
    .convert_enable_n_i, .zero_cross_input_i, .serial_out_o, .serial_out_oe_n_o, .conversion_valid_n_o,
    .phase_code_o);
  // a floated output reads as the inverse, so a late enable corrupts the frame
  ias_host_model u_ias_host_model (.clk_i,
    .serial_out_i(serial_out_oe_n_o ? ~serial_out_o : serial_out_o), .serial_clock_o(serial_clock_i),
    .serial_in_o(serial_in_i), .read_sel_n_o(read_sel_n_i), .load_sel_n_o(load_sel_n_i));
  always #2 clk_i = ~clk_i;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // classic cycle held until ack is sampled
  task automatic wr(input logic [3:0] adr, input logic [31:0] d, input logic [3:0] sel, input logic we = 1);
    int t;
    t = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    wb_sel_i <= sel;
    do begin
      @(posedge clk_i);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    check(wb_ack_o, 1'b1);
  endtask
  task automatic rd(input logic [3:0] adr, input logic [31:0] exp);
    wr(adr, 32'h0, 4'hF, 1'b0);
    check(q, exp);
  endtask
  task automatic wait_phase(input logic [1:0] p);
    int t;
    t = 0;
    while (phase_code_o !== p && t < 6000) begin
      @(posedge clk_i);
      t++;
    end
    check(phase_code_o, p);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // watchdog: the run needs under 30000 cycles
  initial begin
    repeat (60000) @(posedge clk_i);
    n_errors++;
    summarize();
  end
  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    ce_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 4'h0;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    convert_enable_n_i = 1'b0;
    zero_cross_input_i = 1'b0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values, read-only, unmapped, lane 0 only
    rd(4'h0, 32'h0);
    rd(4'h4, 32'h0);
    rd(4'h8, 32'h4);
    wr(4'hC, 32'h3FFFF, 4'hF);
    rd(4'hC, 32'h0);
    rd(4'h2, 32'h0);
    wr(4'h4, 32'h5A, 4'hE);
    rd(4'h4, 32'h0);
    wr(4'h4, 32'h5A, 4'h1);
    rd(4'h4, 32'h5A);
    $display("test registers done");
    u_ias_host_model.load(8'h00, 0);
    rd(4'h4, 32'h80);
    u_ias_host_model.load(8'h01, 0);
    rd(4'h4, 32'h0);
    u_ias_host_model.load(8'hFE, 8);
    rd(4'h4, 32'hFE);
    $display("test load done");
    // comparator level at integrate end picks the sign
    for (int s = 0; s < 2; s++) begin
      zero_cross_input_i <= 1'b1;
      wait_phase(2'h1);
      wait_phase(2'h2);
      zero_cross_input_i <= s[0];
      wait_phase(2'h3);
      zero_cross_input_i <= 1'b1;
      repeat (160) @(posedge clk_i);
      zero_cross_input_i <= 1'b0;
      wait_phase(2'h0);
      u_ias_host_model.read_frame(18, f);
      check(f[17:16], {1'b0, s[0]});
      m = {f[17], f[15:0]};
      check(m >= 17'h00026 && m <= 17'h0002C, 1'b1);
      wr(4'hC, 32'h0, 4'hF, 1'b0);
      check(q[31:16], {15'h0000, s[0]});
      check(q[15:0] >= 16'h0026 && q[15:0] <= 16'h002C, 1'b1);
    end
    u_ias_host_model.read_frame(5, f);
    check(f[4:0], 5'h08);
    check(serial_out_oe_n_o, 1'b1);
    $display("test conversions done");
    zero_cross_input_i <= 1'b1;
    wait_phase(2'h1);
    convert_enable_n_i <= 1'b1;
    repeat (2500) @(posedge clk_i);
    check(conversion_valid_n_o, 1'b0);
    wr(4'h0, 32'h1, 4'h1);
    convert_enable_n_i <= 1'b0;
    repeat (2500) @(posedge clk_i);
    rd(4'h8, 32'h9);
    wr(4'h0, 32'h0, 4'h1);
    wait_phase(2'h2);
    $display("test hold done");
    summarize();
  end
endmodule
`default_nettype wire
